// >>> hw/contact_io_pkg.sv
// Package of register map, field codes and timing constants for the contact I/O block
package contact_io_pkg;
  // Register byte offsets
  localparam logic [11:0] OFF_IN2_CFG = 12'h000;
  localparam logic [11:0] OFF_OUT1_CFG = 12'h004;
  localparam logic [11:0] OFF_OUT2_CFG = 12'h008;
  localparam logic [11:0] OFF_STATUS = 12'h00C;
  // Input two configuration field positions
  localparam int IN2_MODE_LSB = 0;
  localparam int IN2_TIMER_LSB = 4;
  // Output configuration field positions
  localparam int OUT_FUNC_LSB = 0;
  localparam int OUT_NC_BIT = 4;
  localparam int OUT_ALARM_LSB = 8;
  // Input two modes
  typedef enum logic [2:0] {
    IN2_NONE = 3'h0,
    IN2_RUN_STOP = 3'h1,
    IN2_SWITCH_NO = 3'h2,
    IN2_SWITCH_NC = 3'h3,
    IN2_REMOTE = 3'h4
  } in2_mode_t;
  // Output source codes
  typedef enum logic [3:0] {
    SRC_OFF = 4'h0,
    SRC_RUN = 4'h1,
    SRC_REMOTE = 4'h2,
    SRC_READY = 4'h3,
    SRC_HALT_ALARM = 4'h4,
    SRC_CONT_ALARM = 4'h5,
    SRC_ANY_ALARM = 4'h6,
    SRC_SEL_ALARM = 4'h7,
    SRC_START_TMR = 4'h8,
    SRC_STOP_TMR = 4'h9,
    SRC_PWR_REC = 4'hA,
    SRC_ANTIFREEZE = 4'hB,
    SRC_IN1 = 4'hC,
    SRC_IN2 = 4'hD,
    SRC_WARMUP = 4'hE,
    SRC_FILL = 4'hF
  } out_src_t;
  // Reset values and range limits
  localparam logic [2:0] IN2_MODE_RST = 3'h0;
  localparam logic [3:0] IN2_TIMER_RST = 4'h0;
  localparam logic [3:0] IN2_TIMER_MAX = 4'hA;
  localparam logic [3:0] OUT1_FUNC_RST = 4'h1;
  localparam logic [3:0] OUT2_FUNC_RST = 4'h2;
  localparam logic OUT_NC_RST = 1'b0;
  localparam logic [5:0] ALARM_MIN = 6'h01;
  localparam logic [5:0] ALARM_MAX = 6'h30;
  localparam logic [5:0] ALARM_RST = 6'h01;
  // Timing: one second at the 25 MHz bus clock
  localparam int CLK_HZ = 25000000;
  localparam int SECOND_S = 1;
  localparam int SECOND_CYCLES = SECOND_S * CLK_HZ;
endpackage : contact_io_pkg

// >>> hw/contact_io.sv
// Contact input two off-detection and contact outputs one and two source selection
//
// Overview of operation
// R01: Input two off timer 0 to 10 seconds
// R02: Off timer accessible only in switch modes
// R03: Disabled function keeps output silent
// R04: Output may follow running or remote status
// R05: Output may show temperature ready
// R06: Output may show halting or continuing alarm
// R07: Output may show any alarm
// R08: Output may follow one chosen alarm code
// R09: Output may show timer/recovery/antifreeze/warmup enables
// R10: Output may pass input one or two
// R11: Output may show fluid filling in progress
// R12: Defaults: output one running, two remote
// R13: Per-output polarity, normally-open by default
// R14: Alarm code 01 to 48, default 01
// R15: Alarm code accessible only in selected-alarm mode
// R16: Output two has same sixteen independent sources
// R17: Operator keys select, step and commit values; no keys here, each value arrives as one register write
// R18: Input two modes none/run/NO/NC/remote
// R19: Switch off only after stable off time
// R20: Normally-closed output inverts selected source
`timescale 1ns/1ps
module contact_io #(
  parameter int SEC_CYCLES = contact_io_pkg::SECOND_CYCLES // Cycles per second, shortened in simulation
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic in1_pin,
  input wire logic in2_pin,
  input wire logic run_status,
  input wire logic remote_status,
  input wire logic temp_ready,
  input wire logic halting_alarm_source,
  input wire logic continue_alarm_source,
  input wire logic [48:1] alarm_active,
  input wire logic start_timer_enabled_source,
  input wire logic stop_timer_enabled_source,
  input wire logic power_loss_recovery_source,
  input wire logic antifreeze_enabled_source,
  input wire logic warmup_enabled_source,
  input wire logic fill_active,
  output logic out1_contact,
  output logic out2_contact,
  output logic in2_switch_on
);

  // Configuration state
  logic [2:0] in2_mode_r;
  logic [3:0] in2_timer_r;
  logic [3:0] func_r [2];
  logic nc_r [2];
  logic [5:0] alarm_r [2];

  // Pin synchronisers and switch state
  logic [1:0] in1_sync_r;
  logic [1:0] in2_sync_r;
  logic sw_on_r;
  logic [$clog2(SEC_CYCLES)-1:0] tick_cnt_r;
  logic [3:0] off_secs_r;

  // Bus decode
  logic wr_en;
  logic rd_setup; // Read in its setup phase, when the read data is captured
  logic [31:0] rd_mux; // Read data selected by the held address
  logic [31:0] prdata_r; // Read data register, stands for the whole access phase
  logic in2_is_switch;
  logic sw_asserted;
  logic any_alarm;
  logic [15:0] src_vec [2];
  logic src_sel [2];

  assign pready = 1'b1; // Zero-wait slave, answer in the access cycle
  assign wr_en = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign in2_is_switch = (in2_mode_r == contact_io_pkg::IN2_SWITCH_NO) ||
                         (in2_mode_r == contact_io_pkg::IN2_SWITCH_NC);
  assign any_alarm = |alarm_active;

  // Unmapped addresses raise an error in the access phase
  always_comb
  begin
    pslverr = 1'b0;
    if (psel && penable)
    begin
      if (paddr == contact_io_pkg::OFF_IN2_CFG) pslverr = 1'b0;
      else if (paddr == contact_io_pkg::OFF_OUT1_CFG) pslverr = 1'b0;
      else if (paddr == contact_io_pkg::OFF_OUT2_CFG) pslverr = 1'b0;
      else if (paddr == contact_io_pkg::OFF_STATUS) pslverr = 1'b0;
      else pslverr = 1'b1;
    end
  end

  // Input two mode and off timer; out-of-range writes are ignored
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      in2_mode_r <= contact_io_pkg::IN2_MODE_RST;
      in2_timer_r <= contact_io_pkg::IN2_TIMER_RST;
    end
    else if (wr_en && paddr == contact_io_pkg::OFF_IN2_CFG)
    begin
      if (pwdata[contact_io_pkg::IN2_MODE_LSB +: 3] <= 3'(contact_io_pkg::IN2_REMOTE))
        in2_mode_r <= pwdata[contact_io_pkg::IN2_MODE_LSB +: 3]; // see R18
      // Timer is only settable while input two is a switch input
      if (in2_is_switch && pwdata[contact_io_pkg::IN2_TIMER_LSB +: 4] <= contact_io_pkg::IN2_TIMER_MAX)
        in2_timer_r <= pwdata[contact_io_pkg::IN2_TIMER_LSB +: 4]; // see R01 see R02
    end
  end

  // Per-output configuration, one copy per output
  for (genvar g = 0; g < 2; g++)
  begin : g_out
    logic [11:0] my_off;
    logic [5:0] new_alarm;
    assign my_off = (g == 0) ? contact_io_pkg::OFF_OUT1_CFG : contact_io_pkg::OFF_OUT2_CFG;
    assign new_alarm = pwdata[contact_io_pkg::OUT_ALARM_LSB +: 6];

    // Function, polarity and alarm choice of this output
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        func_r[g] <= (g == 0) ? contact_io_pkg::OUT1_FUNC_RST : contact_io_pkg::OUT2_FUNC_RST; // see R12
        nc_r[g] <= contact_io_pkg::OUT_NC_RST; // see R13
        alarm_r[g] <= contact_io_pkg::ALARM_RST; // see R14
      end
      else if (wr_en && paddr == my_off)
      begin
        func_r[g] <= pwdata[contact_io_pkg::OUT_FUNC_LSB +: 4]; // see R16
        nc_r[g] <= pwdata[contact_io_pkg::OUT_NC_BIT];
        // Alarm code only takes a write while already in selected-alarm mode
        if (func_r[g] == contact_io_pkg::SRC_SEL_ALARM &&
            new_alarm >= contact_io_pkg::ALARM_MIN && new_alarm <= contact_io_pkg::ALARM_MAX)
          alarm_r[g] <= new_alarm; // see R14 see R15
      end
    end

    // Sixteen sources indexed by function code
    always_comb
    begin
      src_vec[g] = '0;
      src_vec[g][contact_io_pkg::SRC_OFF] = 1'b0; // see R03
      src_vec[g][contact_io_pkg::SRC_RUN] = run_status; // see R04
      src_vec[g][contact_io_pkg::SRC_REMOTE] = remote_status;
      src_vec[g][contact_io_pkg::SRC_READY] = temp_ready; // see R05
      src_vec[g][contact_io_pkg::SRC_HALT_ALARM] = halting_alarm_source; // see R06
      src_vec[g][contact_io_pkg::SRC_CONT_ALARM] = continue_alarm_source;
      src_vec[g][contact_io_pkg::SRC_ANY_ALARM] = any_alarm; // see R07
      src_vec[g][contact_io_pkg::SRC_SEL_ALARM] = alarm_active[alarm_r[g]]; // see R08
      src_vec[g][contact_io_pkg::SRC_START_TMR] = start_timer_enabled_source; // see R09
      src_vec[g][contact_io_pkg::SRC_STOP_TMR] = stop_timer_enabled_source;
      src_vec[g][contact_io_pkg::SRC_PWR_REC] = power_loss_recovery_source;
      src_vec[g][contact_io_pkg::SRC_ANTIFREEZE] = antifreeze_enabled_source;
      src_vec[g][contact_io_pkg::SRC_IN1] = in1_sync_r[1]; // see R10
      src_vec[g][contact_io_pkg::SRC_IN2] = in2_sync_r[1];
      src_vec[g][contact_io_pkg::SRC_WARMUP] = warmup_enabled_source;
      src_vec[g][contact_io_pkg::SRC_FILL] = fill_active; // see R11
      src_sel[g] = src_vec[g][func_r[g]];
    end
  end

  // Contact drive registered; a disabled output stays open in either polarity
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      out1_contact <= 1'b0;
      out2_contact <= 1'b0;
    end
    else
    begin
      out1_contact <= (func_r[0] == contact_io_pkg::SRC_OFF) ? 1'b0 : (src_sel[0] ^ nc_r[0]); // see R20 see R03
      out2_contact <= (func_r[1] == contact_io_pkg::SRC_OFF) ? 1'b0 : (src_sel[1] ^ nc_r[1]); // see R20
    end
  end

  // Two-flop synchronisers for the contact pins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      in1_sync_r <= 2'b00;
      in2_sync_r <= 2'b00;
    end
    else
    begin
      in1_sync_r <= {in1_sync_r[0], in1_pin};
      in2_sync_r <= {in2_sync_r[0], in2_pin};
    end
  end

  // Normally-closed switch is asserted when the contact opens
  assign sw_asserted = (in2_mode_r == contact_io_pkg::IN2_SWITCH_NC) ? !in2_sync_r[1] : in2_sync_r[1];

  // Off-detection: count whole seconds of continuous deassertion
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tick_cnt_r <= '0;
      off_secs_r <= '0;
      sw_on_r <= 1'b0;
    end
    else if (!in2_is_switch)
    begin
      tick_cnt_r <= '0;
      off_secs_r <= '0;
      sw_on_r <= 1'b0;
    end
    else if (sw_asserted)
    begin
      // Any assertion restarts the off window
      tick_cnt_r <= '0;
      off_secs_r <= '0;
      sw_on_r <= 1'b1;
    end
    else if (off_secs_r >= in2_timer_r)
    begin
      sw_on_r <= 1'b0; // see R19
    end
    else if (tick_cnt_r == ($clog2(SEC_CYCLES))'(SEC_CYCLES - 1))
    begin
      tick_cnt_r <= '0;
      off_secs_r <= off_secs_r + 4'h1; // see R19
    end
    else
    begin
      tick_cnt_r <= tick_cnt_r + 1'b1;
    end
  end

  assign in2_switch_on = sw_on_r;

  // Read mux on the held address; timer field hidden unless a switch mode, alarm hidden unless selected-alarm
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (rd_setup)
    begin
      if (paddr == contact_io_pkg::OFF_IN2_CFG)
      begin
        rd_mux[contact_io_pkg::IN2_MODE_LSB +: 3] = in2_mode_r;
        if (in2_is_switch) rd_mux[contact_io_pkg::IN2_TIMER_LSB +: 4] = in2_timer_r; // see R02
      end
      else if (paddr == contact_io_pkg::OFF_OUT1_CFG)
      begin
        rd_mux[contact_io_pkg::OUT_FUNC_LSB +: 4] = func_r[0];
        rd_mux[contact_io_pkg::OUT_NC_BIT] = nc_r[0];
        if (func_r[0] == contact_io_pkg::SRC_SEL_ALARM) rd_mux[contact_io_pkg::OUT_ALARM_LSB +: 6] = alarm_r[0]; // see R15
      end
      else if (paddr == contact_io_pkg::OFF_OUT2_CFG)
      begin
        rd_mux[contact_io_pkg::OUT_FUNC_LSB +: 4] = func_r[1];
        rd_mux[contact_io_pkg::OUT_NC_BIT] = nc_r[1];
        if (func_r[1] == contact_io_pkg::SRC_SEL_ALARM) rd_mux[contact_io_pkg::OUT_ALARM_LSB +: 6] = alarm_r[1];
      end
      else if (paddr == contact_io_pkg::OFF_STATUS)
      begin
        rd_mux[0] = sw_on_r;
        rd_mux[1] = out1_contact;
        rd_mux[2] = out2_contact;
        rd_mux[7:4] = off_secs_r;
      end
    end
  end

  // Read data is captured at the end of the setup phase, so it stands unchanged through the access
  // phase while pready stays tied high; the price is a value one cycle older than the access edge
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_r <= 32'h0000_0000;
    end
    else if (rd_setup)
    begin
      prdata_r <= rd_mux;
    end
    else
    begin
      prdata_r <= 32'h0000_0000; // Cleared after the access, so idle read data is zero
    end
  end

  assign prdata = prdata_r;

  // Timer never holds more than ten seconds
  timer_range_a: assert property (@(posedge pclk) disable iff (!presetn) // see R01
    in2_timer_r <= contact_io_pkg::IN2_TIMER_MAX) else $error("off timer out of range");

  // Timer unchanged by writes outside switch modes
  timer_lock_a: assert property (@(posedge pclk) disable iff (!presetn) // see R02
    !in2_is_switch |=> $stable(in2_timer_r)) else $error("off timer changed outside switch mode");

  // Disabled output stays open
  off_quiet_a: assert property (@(posedge pclk) disable iff (!presetn) // see R03
    func_r[0] == contact_io_pkg::SRC_OFF |=> !out1_contact) else $error("disabled output driven");

  // Running status follows through on next cycle
  run_follow_a: assert property (@(posedge pclk) disable iff (!presetn) // see R04
    (func_r[0] == contact_io_pkg::SRC_RUN && !nc_r[0]) |=> out1_contact == $past(run_status))
    else $error("output one not following run");

  // Alarm code stays in 1..48
  alarm_range_a: assert property (@(posedge pclk) disable iff (!presetn) // see R14
    alarm_r[1] >= contact_io_pkg::ALARM_MIN && alarm_r[1] <= contact_io_pkg::ALARM_MAX)
    else $error("alarm code out of range");

  // Alarm code locked outside selected-alarm mode
  alarm_lock_a: assert property (@(posedge pclk) disable iff (!presetn) // see R15
    func_r[0] != contact_io_pkg::SRC_SEL_ALARM |=> $stable(alarm_r[0])) else $error("alarm code changed");

  // Inversion under normally-closed polarity
  nc_invert_a: assert property (@(posedge pclk) disable iff (!presetn) // see R20
    (nc_r[1] && func_r[1] != contact_io_pkg::SRC_OFF) |=> out2_contact == !$past(src_sel[1]))
    else $error("normally-closed not inverted");

  // Switch stays on while time not yet elapsed
  off_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // see R19
    (sw_on_r && in2_is_switch && off_secs_r < in2_timer_r) |=> sw_on_r || !$past(in2_is_switch))
    else $error("switch dropped before off time");

  // Output two disabled stays open
  out2_quiet_a: assert property (@(posedge pclk) disable iff (!presetn) // see R03
    func_r[1] == contact_io_pkg::SRC_OFF |=> !out2_contact) else $error("disabled output two driven");

  // Remote status follows through on output two
  remote_follow_a: assert property (@(posedge pclk) disable iff (!presetn) // see R04
    (func_r[1] == contact_io_pkg::SRC_REMOTE && !nc_r[1]) |=> out2_contact == $past(remote_status))
    else $error("output two not following remote");

  // Chosen alarm code closes output one
  sel_alarm_a: assert property (@(posedge pclk) disable iff (!presetn) // see R08
    (func_r[0] == contact_io_pkg::SRC_SEL_ALARM && !nc_r[0] && alarm_active[alarm_r[0]]) |=> out1_contact)
    else $error("selected alarm not shown");

  // Normally-open switch seen closed turns on at the next edge
  switch_set_a: assert property (@(posedge pclk) disable iff (!presetn) // see R18 see R19
    (in2_mode_r == contact_io_pkg::IN2_SWITCH_NO && in2_sync_r[1]) |=> in2_switch_on)
    else $error("switch input not seen");

  // Unmapped access answers with an error
  bad_addr_a: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && paddr > contact_io_pkg::OFF_STATUS) |-> pslverr)
    else $error("unmapped access not refused");

  // Read data stands only in the access phase of a read
  rdata_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
    !(psel && penable && !pwrite) |-> prdata == 32'h0000_0000)
    else $error("read data outside read access");

endmodule : contact_io

// >>> tb/contact_equipment.sv
// External equipment model that closes and opens the dry contact inputs
`timescale 1ns/1ps
module contact_equipment (
  input wire logic pclk,
  input wire logic in1_close,
  input wire logic in2_close,
  output logic in1_pin = 1'b0,
  output logic in2_pin = 1'b0
);
  // Relay contacts move just after an edge; the pins are driven from pclk, and the block still synchronises them
  always @(posedge pclk)
  begin
    in1_pin <= in1_close; // High means contact closed
    in2_pin <= in2_close;
  end
endmodule : contact_equipment

// >>> tb/contact_io_tb_top.sv
// Self-checking bench for input two off detection and output source selection
`timescale 1ns/1ps
module contact_io_tb_top;
  localparam int SEC = 10; // Short second keeps the off-detection runs brief
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [15:0] src_v = 16'h0002; // One bit per source code
  logic [48:1] alm = 48'h0; // Alarm codes raised directly
  logic in2_req = 1'b0; // Input two closed for the timer runs
  logic in1_pin;
  logic in2_pin;
  logic out1_contact;
  logic out2_contact;
  logic in2_switch_on;
  logic [31:0] rd; // Read data of the last transfer
  logic err; // Error flag of the last transfer
  int failures = 0;
  int samples_checked = 0;
  // Clock at 25 MHz
  initial forever #20 pclk = ~pclk;
  contact_equipment u_eq (.pclk(pclk), .in1_close(src_v[12]), .in2_close(src_v[13] | in2_req),
    .in1_pin(in1_pin), .in2_pin(in2_pin));
  contact_io #(.SEC_CYCLES(SEC)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .in1_pin(in1_pin), .in2_pin(in2_pin), .run_status(src_v[1]), .remote_status(src_v[2]),
    .temp_ready(src_v[3]), .halting_alarm_source(src_v[4]), .continue_alarm_source(src_v[5]),
    .alarm_active(alm | {47'h0, src_v[6] | src_v[7]}), .start_timer_enabled_source(src_v[8]),
    .stop_timer_enabled_source(src_v[9]), .power_loss_recovery_source(src_v[10]),
    .antifreeze_enabled_source(src_v[11]), .warmup_enabled_source(src_v[14]), .fill_active(src_v[15]),
    .out1_contact(out1_contact), .out2_contact(out2_contact), .in2_switch_on(in2_switch_on));
  // Verdict and end of run
  task automatic summarize();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : summarize
  // Compare a seen value with its expectation
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask : check
  // One APB transfer; the answer is awaited under a bound, no latency is assumed
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      failures++;
      summarize();
    end
  endtask : apb
  // Wait covering source register plus the model and synchroniser stages
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask : tick
  // Watchdog against a hung run
  initial
  begin
    repeat (100000) @(posedge pclk);
    failures++;
    summarize();
  end
  // Main sequence; each write stands for a value chosen and committed from the panel
  initial
  begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    tick(3);
    check("out1 run", 32'(out1_contact), 32'h1);
    check("out2 run", 32'(out2_contact), 32'h0);
    apb(1'b0, contact_io_pkg::OFF_OUT1_CFG, 32'h0);
    check("out1 cfg", rd, 32'h1);
    apb(1'b0, contact_io_pkg::OFF_OUT2_CFG, 32'h0);
    check("out2 cfg", rd, 32'h2);
    apb(1'b0, 12'h010, 32'h0);
    check("unmapped err", 32'(err), 32'h1);
    // Every source code, open and closed polarity
    for (int f = 0; f < 16; f++)
    begin
      apb(1'b1, contact_io_pkg::OFF_OUT1_CFG, 32'(f));
      src_v <= 16'h0001 << f;
      tick(6);
      check("src on", 32'(out1_contact), 32'(f != 0));
      src_v <= 16'h0;
      tick(6);
      check("src off", 32'(out1_contact), 32'h0);
      apb(1'b1, contact_io_pkg::OFF_OUT1_CFG, 32'(f) | 32'h10);
      tick(6);
      check("nc", 32'(out1_contact), 32'(f != 0));
    end
    apb(1'b1, contact_io_pkg::OFF_OUT1_CFG, 32'h5);
    apb(1'b1, contact_io_pkg::OFF_OUT2_CFG, 32'h4);
    src_v <= 16'h0010;
    tick(3);
    check("indep out1", 32'(out1_contact), 32'h0);
    check("indep out2", 32'(out2_contact), 32'h1);
    src_v <= 16'h0;
    // Alarm code follows the function held before the write
    apb(1'b1, contact_io_pkg::OFF_OUT1_CFG, 32'h7);
    apb(1'b1, contact_io_pkg::OFF_OUT1_CFG, 32'h3007);
    apb(1'b1, contact_io_pkg::OFF_OUT1_CFG, 32'h3107);
    apb(1'b1, contact_io_pkg::OFF_OUT1_CFG, 32'h0007);
    apb(1'b0, contact_io_pkg::OFF_OUT1_CFG, 32'h0);
    check("code 48", rd, 32'h3007);
    alm <= 48'h8000_0000_0000;
    tick(3);
    check("sel hit", 32'(out1_contact), 32'h1);
    alm <= 48'h1;
    tick(3);
    check("sel miss", 32'(out1_contact), 32'h0);
    apb(1'b1, contact_io_pkg::OFF_OUT2_CFG, 32'h0504);
    apb(1'b0, contact_io_pkg::OFF_OUT2_CFG, 32'h0);
    check("hidden code", rd, 32'h4);
    apb(1'b1, contact_io_pkg::OFF_OUT2_CFG, 32'h7);
    apb(1'b0, contact_io_pkg::OFF_OUT2_CFG, 32'h0);
    check("code dflt", rd, 32'h107);
    // Output two in normally-closed polarity on its chosen alarm
    apb(1'b1, contact_io_pkg::OFF_OUT2_CFG, 32'h117);
    tick(3);
    check("out2 nc hit", 32'(out2_contact), 32'h0);
    alm <= 48'h0;
    tick(3);
    check("out2 nc idle", 32'(out2_contact), 32'h1);
    // Input two modes and the off timer
    apb(1'b1, contact_io_pkg::OFF_IN2_CFG, 32'h50);
    apb(1'b0, contact_io_pkg::OFF_IN2_CFG, 32'h0);
    check("timer gated", rd, 32'h0);
    for (int m = 0; m < 6; m++)
    begin
      apb(1'b1, contact_io_pkg::OFF_IN2_CFG, 32'(m));
      apb(1'b0, contact_io_pkg::OFF_IN2_CFG, 32'h0);
      check("in2 mode", rd, (m < 5) ? 32'(m) : 32'h4);
    end
    apb(1'b1, contact_io_pkg::OFF_IN2_CFG, 32'h2);
    apb(1'b1, contact_io_pkg::OFF_IN2_CFG, 32'hA2);
    apb(1'b1, contact_io_pkg::OFF_IN2_CFG, 32'hB2);
    apb(1'b0, contact_io_pkg::OFF_IN2_CFG, 32'h0);
    check("timer 10", rd, 32'hA2);
    apb(1'b1, contact_io_pkg::OFF_IN2_CFG, 32'h32);
    in2_req <= 1'b1;
    tick(8);
    check("sw on", 32'(in2_switch_on), 32'h1);
    in2_req <= 1'b0;
    tick(20);
    check("sw held", 32'(in2_switch_on), 32'h1);
    tick(20);
    check("sw off", 32'(in2_switch_on), 32'h0);
    apb(1'b0, contact_io_pkg::OFF_STATUS, 32'h0);
    check("status sw", 32'(rd[0]), 32'h0);
    apb(1'b1, contact_io_pkg::OFF_IN2_CFG, 32'h33);
    tick(8);
    check("nc sw on", 32'(in2_switch_on), 32'h1);
    summarize();
  end
endmodule : contact_io_tb_top
